/* logic/srp_device.sv */
// srp_device: device end of the serial register port with holding and active registers
// assumes: link pins are asynchronous to mclk; mclk is much faster than sclk
//
// Summary of operation
// RULE1: command byte first, then register data phase
// RULE2: bit 7 direction, bits 4..0 register index
// RULE3: data phase covers every byte of register
// RULE4: write bits captured on rising serial clock
// RULE5: host always sends the full register length
// RULE6: abort input ends transfer, next byte commands
// RULE7: abort keeps whole bytes, drops partial byte
// RULE8: after a transfer, eight edges form command
// RULE9: written data waits in holding until commit
// RULE10: profile pin change also commits holding data
// RULE11: reads return active data, driven on falling edge
// RULE12: profile reads need matching profile pin pattern
// RULE13: profile writes accepted whatever the pins show
// RULE14: msb-first or lsb-first shift order selectable
// RULE15: two-wire or three-wire pin usage selectable
// RULE16: direction flag one reads, zero writes
// RULE17: chip select high suspends transfer, outputs float
// RULE18: lsb-first order covers command byte too
// RULE19: wire mode in control word one, default two-wire
// RULE20: command bits six and five ignored
//
// Our own choices: the address map and the APB interface to the registers.
`default_nettype none
module srp_device (
    input wire logic mclk,
    input wire logic resetn,
    srp_if.dev link,
    input wire logic [srp_pkg::IDX_W-1:0] act_idx,
    output var srp_pkg::srp_word_t act_data,
    output var logic commit_seen
);
    import srp_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int PIN_W = 8;
    localparam logic [PIN_W-1:0] PIN_INIT = 8'h60;
    logic [PIN_W-1:0] pins_f;
    logic sclk_f;
    logic cs_n_f;
    logic sdio_f;
    logic ioreset_f;
    logic upd_f;
    logic [2:0] prof_f;

    srp_sync #(.W(PIN_W), .INIT(PIN_INIT)) u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .din({link.sclk, link.cs_n, link.sdio_line, link.io_reset, link.io_update,
              link.profile}),
        .dout(pins_f)
    );
    assign {sclk_f, cs_n_f, sdio_f, ioreset_f, upd_f, prof_f} = pins_f;

    // ****************************************
    // state
    // ****************************************
    srp_dev_state_e st;
    srp_dev_state_e next_st;
    logic [2:0] bitcnt;
    logic [2:0] next_bitcnt;
    logic [3:0] bytecnt;
    logic [3:0] next_bytecnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic rd;
    logic next_rd;
    logic [4:0] idx;
    logic [4:0] next_idx;
    srp_word_t rdword;
    srp_word_t next_rdword;
    logic drv;
    logic next_drv;
    logic dout;
    logic next_dout;
    logic sdio_oe;
    logic next_sdio_oe;
    logic out_oe;
    logic next_out_oe;
    logic sclk_q;
    logic upd_q;
    logic [2:0] prof_q;
    srp_word_t hold [REG_COUNT];
    srp_word_t next_hold [REG_COUNT];
    srp_word_t act [REG_COUNT];
    srp_word_t next_act [REG_COUNT];
    srp_word_t next_act_data;
    logic next_commit_seen;

    // ****************************************
    // decode helpers
    // ****************************************
    logic rise;
    logic fall;
    logic lsb;
    logic three;
    logic commit;
    logic [3:0] nbytes;
    logic [2:0] bytepos;
    logic [5:0] bitpos;
    logic [7:0] sh_in;
    logic [4:0] cmd_idx;
    logic [4:0] src_idx;

    // edges only count while selected; cs high freezes the transfer
    assign rise = sclk_f & ~sclk_q & ~cs_n_f; // RULE17
    assign fall = ~sclk_f & sclk_q & ~cs_n_f; // RULE17
    // shape of the port follows the active copy of control word one
    assign lsb = act[CW1_INDEX][CW1_LSB_FIRST_BIT]; // RULE14 RULE19
    assign three = act[CW1_INDEX][CW1_THREE_WIRE_BIT]; // RULE15 RULE19
    assign commit = (upd_f & ~upd_q) | (prof_f != prof_q); // RULE9 RULE10
    assign nbytes = srp_reg_bytes(idx); // RULE3
    assign bytepos = lsb ? bytecnt[2:0] : 3'(nbytes - 4'h1 - bytecnt);
    assign bitpos = srp_bit_pos({bytecnt[2:0], bitcnt}, nbytes, lsb);
    // same order for command and data bytes
    assign sh_in = lsb ? {sdio_f, shreg[7:1]} : {shreg[6:0], sdio_f}; // RULE14 RULE18
    assign cmd_idx = sh_in[IDX_W-1:0]; // RULE2 RULE20
    // profile reads follow the pins, not the index, within the profile range
    assign src_idx = (cmd_idx >= PROFILE_FIRST && cmd_idx <= PROFILE_LAST) ?
                     5'(PROFILE_FIRST + {2'h0, prof_f}) : cmd_idx; // RULE12

    // ****************************************
    // sequencer
    // ****************************************
    always_comb begin
        next_st = st;
        next_bitcnt = bitcnt;
        next_bytecnt = bytecnt;
        next_shreg = shreg;
        next_rd = rd;
        next_idx = idx;
        next_rdword = rdword;
        next_drv = drv;
        next_dout = dout;
        next_hold = hold;
        next_act = act;
        if (ioreset_f) begin
            // holding buffer untouched; a half-shifted byte is simply lost
            next_st = SRP_ST_CMD; // RULE6
            next_bitcnt = 3'h0; // RULE6 RULE7
            next_bytecnt = 4'h0; // RULE6
            next_shreg = 8'h00; // RULE7
            next_drv = 1'h0;
        end else if (rise) begin
            next_shreg = sh_in; // RULE4
            next_bitcnt = 3'(bitcnt + 3'h1);
            if (bitcnt == 3'h7) begin
                if (st == SRP_ST_CMD) begin
                    next_rd = sh_in[CMD_RD_BIT]; // RULE16
                    next_idx = cmd_idx; // RULE2
                    next_rdword = act[src_idx]; // RULE11
                    next_bytecnt = 4'h0;
                    next_st = SRP_ST_DATA; // RULE1
                end else begin
                    if (!rd) begin
                        next_hold[idx][{bytepos, 3'h0} +: 8] = sh_in; // RULE9 RULE13
                    end
                    if (bytecnt == nbytes - 4'h1) begin
                        next_st = SRP_ST_CMD; // RULE8
                        next_bytecnt = 4'h0;
                        next_drv = 1'h0;
                    end else begin
                        next_bytecnt = 4'(bytecnt + 4'h1); // RULE3
                    end
                end
            end
        end else if (fall && st == SRP_ST_DATA && rd) begin
            next_drv = 1'h1;
            next_dout = rdword[bitpos]; // RULE11
        end
        // a write landing in the same cycle waits for the next commit
        if (commit) begin
            next_act = hold; // RULE9 RULE10
        end
        next_commit_seen = commit;
        next_act_data = act[act_idx];
        next_sdio_oe = drv & ~three & ~cs_n_f; // RULE15 RULE17
        next_out_oe = drv & three & ~cs_n_f; // RULE15 RULE17
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= SRP_ST_CMD;
            bitcnt <= 3'h0;
            bytecnt <= 4'h0;
            shreg <= 8'h00;
            rd <= 1'h0;
            idx <= 5'h00;
            rdword <= REG_RESET;
            drv <= 1'h0;
            dout <= 1'h0;
            sdio_oe <= 1'h0;
            out_oe <= 1'h0;
            sclk_q <= 1'h0;
            upd_q <= 1'h0;
            prof_q <= 3'h0;
            hold <= '{default: REG_RESET}; // RULE19
            act <= '{default: REG_RESET}; // RULE19
            act_data <= REG_RESET;
            commit_seen <= 1'h0;
        end else begin
            st <= next_st;
            bitcnt <= next_bitcnt;
            bytecnt <= next_bytecnt;
            shreg <= next_shreg;
            rd <= next_rd;
            idx <= next_idx;
            rdword <= next_rdword;
            drv <= next_drv;
            dout <= next_dout;
            sdio_oe <= next_sdio_oe;
            out_oe <= next_out_oe;
            sclk_q <= sclk_f;
            upd_q <= upd_f;
            prof_q <= prof_f;
            hold <= next_hold;
            act <= next_act;
            act_data <= next_act_data;
            commit_seen <= next_commit_seen;
        end
    end

    // ****************************************
    // pin drivers
    // ****************************************
    assign link.dev_sdio = dout;
    assign link.dev_sdio_oe = sdio_oe;
    assign link.dev_out = dout;
    assign link.dev_out_oe = out_oe;
endmodule : srp_device
`default_nettype wire

/* logic/srp_pkg.sv */
// srp_pkg: constants, types and helpers shared by both ends of the serial register port
// assumes: compiled first; both ends and the bench import it
`default_nettype none
package srp_pkg;
    localparam int IDX_W = 5;
    localparam int REG_COUNT = 32;
    localparam int WORD_W = 64;
    localparam int CMD_RD_BIT = 7;
    localparam int CW1_LSB_FIRST_BIT = 0;
    localparam int CW1_THREE_WIRE_BIT = 1;
    localparam logic [6:0] CMD_BITS = 7'h08;
    localparam logic [4:0] CW1_INDEX = 5'h00;
    localparam logic [4:0] PROFILE_FIRST = 5'h0E;
    localparam logic [4:0] PROFILE_LAST = 5'h15;
    localparam logic [3:0] PROFILE_BYTES = 4'h8;
    localparam logic [3:0] CONTROL_BYTES = 4'h4;
    localparam logic [63:0] REG_RESET = 64'h0;
    // serial clock made by the host: half period as a time, then in mclk cycles
    localparam int MCLK_PERIOD_NS = 25;
    localparam int SCLK_HALF_NS = 400;
    localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    // ****************************************
    // host apb register map
    // ****************************************
    localparam logic [11:0] HOST_CMD = 12'h000;
    localparam logic [11:0] HOST_CFG = 12'h004;
    localparam logic [11:0] HOST_WDATA_LO = 12'h008;
    localparam logic [11:0] HOST_WDATA_HI = 12'h00C;
    localparam logic [11:0] HOST_RDATA_LO = 12'h010;
    localparam logic [11:0] HOST_RDATA_HI = 12'h014;
    localparam logic [11:0] HOST_STATUS = 12'h018;
    localparam int HCFG_W = 7;
    localparam int HCFG_LSB_BIT = 0;
    localparam int HCFG_THREE_BIT = 1;
    localparam int HCFG_PROFILE_LSB = 2;
    localparam int HCFG_IO_RESET_BIT = 5;
    localparam int HCFG_IO_UPDATE_BIT = 6;
    typedef logic [WORD_W-1:0] srp_word_t;
    typedef enum {SRP_ST_CMD, SRP_ST_DATA} srp_dev_state_e;
    typedef enum {SRP_HS_IDLE, SRP_HS_RUN} srp_host_state_e;
    function automatic logic [3:0] srp_reg_bytes(input logic [4:0] idx);
        srp_reg_bytes = (idx >= PROFILE_FIRST && idx <= PROFILE_LAST) ?
                        PROFILE_BYTES : CONTROL_BYTES;
    endfunction : srp_reg_bytes
    // bit k of the data phase lands on this register bit
    function automatic logic [5:0] srp_bit_pos(input logic [5:0] k, input logic [3:0] nbytes,
                                               input logic lsb);
        logic [6:0] nbits;
        nbits = {nbytes, 3'h0};
        srp_bit_pos = lsb ? k : 6'(nbits - 7'h01 - {1'h0, k});
    endfunction : srp_bit_pos
endpackage : srp_pkg
`default_nettype wire

/* logic/srp_if.sv */
// srp_if: the serial link between host and device
// assumes: each end drives only its own signals; undriven lines idle high
`default_nettype none
interface srp_if;
    logic sclk;
    logic cs_n;
    logic host_sdio;
    logic host_sdio_oe;
    logic dev_sdio;
    logic dev_sdio_oe;
    logic dev_out;
    logic dev_out_oe;
    logic io_reset;
    logic io_update;
    logic [2:0] profile;
    logic sdio_line;
    logic serial_data_out_pin;
    // pull-up behaviour stands in for a floating line
    assign sdio_line = host_sdio_oe ? host_sdio : (dev_sdio_oe ? dev_sdio : 1'h1);
    assign serial_data_out_pin = dev_out_oe ? dev_out : 1'h1;
    modport dev (input sclk, cs_n, sdio_line, io_reset, io_update, profile,
                 output dev_sdio, dev_sdio_oe, dev_out, dev_out_oe);
    modport host (output sclk, cs_n, host_sdio, host_sdio_oe, io_reset, io_update, profile,
                  input sdio_line, serial_data_out_pin);
endinterface : srp_if
`default_nettype wire

/* logic/srp_sync.sv */
// srp_sync: three-stage input synchroniser with agreement filter, one per bit
// assumes: inputs come from outside the mclk domain
`default_nettype none
module srp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        logic s1;
        logic s2;
        logic s3;
        logic o;
        logic next_o;
        // a change counts only once stages two and three agree
        always_comb begin
            next_o = (s2 == s3) ? s3 : o;
        end
        always_ff @(posedge mclk) begin
            if (!resetn) begin
                s1 <= INIT[i];
                s2 <= INIT[i];
                s3 <= INIT[i];
                o <= INIT[i];
            end else begin
                s1 <= din[i];
                s2 <= s1;
                s3 <= s2;
                o <= next_o;
            end
        end
        assign dout[i] = o;
    end
endmodule : srp_sync
`default_nettype wire

/* logic/srp_host.sv */
// srp_host: apb-controlled master that runs transfers on the serial register port
// assumes: software keeps the wire mode and bit order equal to the device's active setting
`default_nettype none
module srp_host (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    srp_if.host link
);
    import srp_pkg::*;

    // ****************************************
    // returning data lines
    // ****************************************
    logic sdio_f;
    logic out_f;
    srp_sync #(.W(2), .INIT(2'h3)) u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .din({link.sdio_line, link.serial_data_out_pin}),
        .dout({sdio_f, out_f})
    );

    srp_host_state_e st, next_st;
    logic [7:0] cmd, next_cmd;
    logic [HCFG_W-1:0] cfg, next_cfg;
    srp_word_t wdata, next_wdata, rdata, next_rdata;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [7:0] cnt, next_cnt;
    logic [6:0] bitnum, next_bitnum;
    logic sclk, next_sclk, cs_n, next_cs_n, dout, next_dout, doe, next_doe;
    logic lsb, rdcmd, rx, tick, setup, access;
    logic [3:0] nbytes;

    assign lsb = cfg[HCFG_LSB_BIT];
    assign rdcmd = cmd[CMD_RD_BIT];
    assign nbytes = srp_reg_bytes(cmd[IDX_W-1:0]);
    assign rx = cfg[HCFG_THREE_BIT] ? out_f : sdio_f;
    assign tick = (cnt == 8'(SCLK_HALF_CYCLES - 1));
    assign setup = psel & ~penable;
    assign access = psel & penable & pready;

    // value of outgoing bit n of a transfer
    function automatic logic tx_bit(input logic [6:0] n, input logic [7:0] c,
                                    input srp_word_t w, input logic l, input logic [3:0] nb);
        logic [6:0] k;
        k = 7'(n - CMD_BITS);
        if (n < CMD_BITS) begin
            tx_bit = l ? c[n[2:0]] : c[3'(3'h7 - n[2:0])];
        end else begin
            tx_bit = w[srp_bit_pos(k[5:0], nb, l)];
        end
    endfunction : tx_bit

    // ****************************************
    // apb slave and transfer engine
    // ****************************************
    always_comb begin
        next_st = st;
        next_cmd = cmd;
        next_cfg = cfg;
        next_wdata = wdata;
        next_rdata = rdata;
        next_prdata = prdata;
        next_pslverr = 1'h0;
        next_pready = setup;
        next_cnt = cnt;
        next_bitnum = bitnum;
        next_sclk = sclk;
        next_cs_n = cs_n;
        next_dout = dout;
        next_doe = doe;
        if (setup) begin
            case (paddr)
                HOST_CMD: next_prdata = {24'h0, cmd};
                HOST_CFG: next_prdata = {25'h0, cfg};
                HOST_WDATA_LO: next_prdata = wdata[31:0];
                HOST_WDATA_HI: next_prdata = wdata[63:32];
                HOST_RDATA_LO: next_prdata = rdata[31:0];
                HOST_RDATA_HI: next_prdata = rdata[63:32];
                HOST_STATUS: next_prdata = {31'h0, st == SRP_HS_RUN};
                default: begin
                    next_prdata = 32'h0;
                    next_pslverr = 1'h1;
                end
            endcase
        end
        if (st == SRP_HS_RUN) begin
            next_cnt = tick ? 8'h00 : 8'(cnt + 8'h01);
            if (tick && !sclk) begin
                next_sclk = 1'h1;
                next_bitnum = 7'(bitnum + 7'h01);
                if (rdcmd && bitnum >= CMD_BITS) begin
                    next_rdata[srp_bit_pos(6'(bitnum - CMD_BITS), nbytes, lsb)] = rx;
                end
            end else if (tick) begin
                next_sclk = 1'h0;
                // whole register always sent, never cut short
                if (bitnum == 7'(CMD_BITS + {nbytes, 3'h0})) begin // RULE5
                    next_st = SRP_HS_IDLE;
                    next_cs_n = 1'h1;
                    next_doe = 1'h0;
                end else begin
                    next_dout = tx_bit(bitnum, cmd, wdata, lsb, nbytes); // RULE1 RULE18
                    next_doe = ~(rdcmd && bitnum >= CMD_BITS); // RULE16
                end
            end
        end
        if (access && pwrite) begin
            case (paddr)
                HOST_CMD: begin
                    // a command while busy is dropped; status shows why
                    if (st == SRP_HS_IDLE) begin
                        next_cmd = pwdata[7:0]; // RULE2
                        next_st = SRP_HS_RUN;
                        next_cs_n = 1'h0;
                        next_cnt = 8'h00;
                        next_bitnum = 7'h00;
                        next_sclk = 1'h0;
                        next_dout = tx_bit(7'h00, pwdata[7:0], wdata, lsb, nbytes);
                        next_doe = 1'h1;
                    end
                end
                HOST_CFG: next_cfg = pwdata[HCFG_W-1:0]; // RULE12
                HOST_WDATA_LO: next_wdata[31:0] = pwdata;
                HOST_WDATA_HI: next_wdata[63:32] = pwdata;
                default: next_cfg = cfg;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= SRP_HS_IDLE;
            cmd <= 8'h00;
            cfg <= '0;
            wdata <= REG_RESET;
            rdata <= REG_RESET;
            prdata <= 32'h0;
            pready <= 1'h0;
            pslverr <= 1'h0;
            cnt <= 8'h00;
            bitnum <= 7'h00;
            sclk <= 1'h0;
            cs_n <= 1'h1;
            dout <= 1'h0;
            doe <= 1'h0;
        end else begin
            st <= next_st;
            cmd <= next_cmd;
            cfg <= next_cfg;
            wdata <= next_wdata;
            rdata <= next_rdata;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            cnt <= next_cnt;
            bitnum <= next_bitnum;
            sclk <= next_sclk;
            cs_n <= next_cs_n;
            dout <= next_dout;
            doe <= next_doe;
        end
    end

    assign link.sclk = sclk;
    assign link.cs_n = cs_n;
    assign link.host_sdio = dout;
    assign link.host_sdio_oe = doe;
    assign link.io_reset = cfg[HCFG_IO_RESET_BIT];
    assign link.io_update = cfg[HCFG_IO_UPDATE_BIT];
    assign link.profile = cfg[HCFG_PROFILE_LSB +: 3];
endmodule : srp_host
`default_nettype wire

/* bench/srp_monitor.sv */
// srp_monitor: wire-level checks on the serial link between host and device
// assumes: fed straight from the interface signals; host sclk is made from mclk flops
`default_nettype none
module srp_monitor (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic host_sdio,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio,
    input wire logic dev_sdio_oe,
    input wire logic dev_out,
    input wire logic dev_out_oe,
    input wire logic io_reset
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // rise count per frame
    // ****************
    logic sclk_q;
    logic [6:0] cnt;
    logic [6:0] next_cnt;
    logic drv;
    always_comb begin
        next_cnt = cs_n ? 7'h00 : cnt + 7'(sclk & ~sclk_q);
    end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sclk_q <= 1'h0;
            cnt <= 7'h00;
        end else begin
            sclk_q <= sclk;
            cnt <= next_cnt;
        end
    end
    assign drv = dev_sdio_oe | dev_out_oe;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // device sync lag is a few cycles, so deselect must last before drive is judged
    a_cs_float: assert property (cs_n [*8] |-> !drv)
        else $error("device drives while deselected");
    a_abort_float: assert property (io_reset [*8] |-> !drv)
        else $error("device drives during abort");
    a_no_fight: assert property (!(host_sdio_oe && dev_sdio_oe))
        else $error("both ends drive the two-way line");
    a_one_out_pin: assert property (!(dev_sdio_oe && dev_out_oe))
        else $error("device drives both data pins");
    a_dev_change_low: assert property ((dev_sdio_oe && $changed(dev_sdio))
        || (dev_out_oe && $changed(dev_out)) |-> !sclk)
        else $error("device data moved while clock high");
    a_dev_start_low: assert property ($rose(dev_sdio_oe) || $rose(dev_out_oe) |-> !sclk)
        else $error("device drive began while clock high");
    a_host_change_low: assert property (host_sdio_oe && $past(host_sdio_oe)
        && $changed(host_sdio) |-> !sclk)
        else $error("host data moved while clock high");
    a_cmd_quiet: assert property (!cs_n && cnt < 7'h08 |-> !drv)
        else $error("device drives during command byte");
    a_frame_rises: assert property ($rose(cs_n) |-> cnt == 7'h28 || cnt == 7'h48)
        else $error("frame rise count wrong");
    c_two_wire_read: cover property ($rose(dev_sdio_oe));
    c_three_wire_read: cover property ($rose(dev_out_oe));
    c_long_frame: cover property ($rose(cs_n) && cnt == 7'h48);
endmodule : srp_monitor
`default_nettype wire

/* bench/test_serial_register_port.sv */
// test_serial_register_port: host and device joined, driven over apb
// assumes: host answers apb with zero wait states; device act view lags one cycle
`default_nettype none
module test_serial_register_port;
    timeunit 1ns;
    timeprecision 100ps;
    import srp_pkg::*;
    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] act_idx = 5'h00;
    srp_word_t act_data;
    logic commit_seen;
    logic [31:0] rd;
    logic err;
    srp_word_t rv;
    logic [6:0] cfg = 7'h00;
    int bad_count = 0;
    int checks_done = 0;
    int commits = 0;
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (commit_seen === 1'h1) commits <= commits + 1;
    end
    srp_if srp_if_inst ();
    srp_host srp_host_inst (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .link(srp_if_inst));
    srp_device srp_device_inst (.mclk, .resetn, .link(srp_if_inst), .act_idx, .act_data,
        .commit_seen);
    srp_monitor srp_monitor_inst (.mclk, .resetn, .sclk(srp_if_inst.sclk),
        .cs_n(srp_if_inst.cs_n), .host_sdio(srp_if_inst.host_sdio),
        .host_sdio_oe(srp_if_inst.host_sdio_oe), .dev_sdio(srp_if_inst.dev_sdio),
        .dev_sdio_oe(srp_if_inst.dev_sdio_oe), .dev_out(srp_if_inst.dev_out),
        .dev_out_oe(srp_if_inst.dev_out_oe), .io_reset(srp_if_inst.io_reset));
    // ****************
    // tasks
    // ****************
    task automatic test_done();
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        // no give-up here: only the watchdog ends a hung transfer
        do begin
            @(posedge mclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'h0, HOST_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'h0 && n < 3000);
        if (n >= 3000) bad_count++;
        repeat (40) @(posedge mclk);
    endtask : wait_idle
    task automatic wr(input logic [7:0] cmd, input logic [63:0] v);
        apb(1'h1, HOST_WDATA_LO, v[31:0]);
        apb(1'h1, HOST_WDATA_HI, v[63:32]);
        apb(1'h1, HOST_CMD, {24'h0, cmd});
        wait_idle();
    endtask : wr
    task automatic rdreg(input logic [7:0] cmd);
        apb(1'h1, HOST_CMD, {24'h0, cmd});
        wait_idle();
        apb(1'h0, HOST_RDATA_LO, 32'h0);
        rv[31:0] = rd;
        apb(1'h0, HOST_RDATA_HI, 32'h0);
        rv[63:32] = rd;
    endtask : rdreg
    // strobe held several cycles so the device filter sees it
    task automatic commit();
        apb(1'h1, HOST_CFG, 32'(cfg) | 32'h40);
        repeat (8) @(posedge mclk);
        apb(1'h1, HOST_CFG, 32'(cfg));
        repeat (12) @(posedge mclk);
    endtask : commit
    task automatic act(input logic [4:0] idx, input logic [63:0] exp);
        act_idx <= idx;
        repeat (3) @(posedge mclk);
        chk(act_data, exp);
    endtask : act
    // ****************
    // scenarios
    // ****************
    task automatic s_write();
        int c;
        apb(1'h0, 12'h0FC, 32'h0);
        chk({err, rd}, {1'h1, 32'h0});
        c = commits;
        wr(8'h61, 64'hA5C30F96);
        act(5'h01, 64'h0);
        commit();
        act(5'h01, 64'hA5C30F96);
        chk(commits - c, 64'h1);
    endtask : s_write
    task automatic s_read();
        rdreg(8'hE1);
        chk(rv[31:0], 32'hA5C30F96);
        wr(8'h01, 64'h12345678);
        rdreg(8'h81);
        chk(rv[31:0], 32'hA5C30F96);
    endtask : s_read
    task automatic s_abort();
        apb(1'h1, HOST_WDATA_LO, 32'hDEADBEEF);
        apb(1'h1, HOST_CMD, 32'h04);
        repeat (28) @(posedge srp_if_inst.sclk);
        repeat (4) @(posedge mclk);
        apb(1'h1, HOST_CFG, 32'(cfg) | 32'h20);
        wait_idle();
        apb(1'h1, HOST_CFG, 32'(cfg));
        commit();
        act(5'h04, 64'hDEAD0000);
        rdreg(8'h84);
        chk(rv[31:0], 32'hDEAD0000);
    endtask : s_abort
    task automatic s_profile();
        int c;
        wr(8'h13, 64'h0123456789ABCDEF);
        c = commits;
        cfg[4:2] = 3'h5;
        apb(1'h1, HOST_CFG, 32'(cfg));
        repeat (20) @(posedge mclk);
        chk(commits - c, 64'h1);
        act(5'h13, 64'h0123456789ABCDEF);
        rdreg(8'h93);
        chk(rv, 64'h0123456789ABCDEF);
    endtask : s_profile
    // modes walked lsb, lsb three-wire, three-wire, back to default
    task automatic s_modes();
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = (i == 0) ? 2'h1 : (i == 1) ? 2'h3 : (i == 2) ? 2'h2 : 2'h0;
            wr(8'h00, {62'h0, m});
            commit();
            cfg[1:0] = m;
            apb(1'h1, HOST_CFG, 32'(cfg));
            wr(8'h02, 64'h8421C0E0 + 64'(i));
            commit();
            act(5'h02, 64'h8421C0E0 + 64'(i));
            rdreg(8'h82);
            chk(rv[31:0], 32'h8421C0E0 + 32'(i));
        end
    endtask : s_modes
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'h1;
        repeat (10) @(posedge mclk);
        s_write();
        s_read();
        s_abort();
        s_profile();
        s_modes();
        test_done();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        bad_count++;
        test_done();
    end
endmodule : test_serial_register_port
`default_nettype wire
